// File: common/fault_regs_pkg.sv
/*
  constants, field layouts and carriers for the per-bank fault status,
  fault syndrome and memory type index registers.
  assumes a plain register port with one-cycle strobes and read data one cycle later.
*/
// Functional notes
// - record unsupported-request fault by setting its flag to one
// - status bit 7 flags an address size fault
// - status bit 6 flags a tlb lock fault, may be read-zero
// - status bit 5 flags tlb multi-match, may be read-zero
// - status bit 4 flags an external fault, may be read-zero
// - status bit 3 flags a permission fault
// - status bit 2 flags an access flag fault
// - status bit 1 flags a translation fault; bit 0 reserved
// - restore write replaces status except format field and stall bit
// - only a resume write clears the stall bit
// - syndrome bits 23:16 hold first-stage bank index for nested translation
// - bank index kept only with nested support, else reads zero, ignores writes
// - syndrome bit 11 says synchronous or asynchronous recording
// - syndrome bit 10 set only for external fault during a walk
// - syndrome bit 8 holds security attribute in secure banks only
// - syndrome bit 6 holds instruction flag after override
// - syndrome bit 5 holds privileged flag after override
// - syndrome bit 4 holds write flag, far atomics show missing permission
// - syndrome bits 1:0 encode table level zero to three
// - walk faults report walked level; disabled walk gives scheme base level
// - access flag faults report faulting level, permission faults final level
// - two index registers hold four memory type bytes each, lowest index low
// - writing one clears a status flag bit, writing zero leaves it; stall and format bits ignore the write
// - repeat flag bit 31 set when fault arrives with any status flag already set
package fault_regs_pkg;

  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] RESTORE_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] SYN_PRI_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] SYN_EXT_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] MEM_LOW_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] MEM_HIGH_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] RESUME_OFS = 8'h18;

  // status field positions
  localparam int ST_REPEAT = 31;
  localparam int ST_STALL = 30;
  localparam int ST_FMT_HI = 10;
  localparam int ST_FMT_LO = 9;
  localparam int ST_UNSUP = 8;
  localparam int ST_ASIZE = 7;
  localparam int ST_TLBLK = 6;
  localparam int ST_TLBMM = 5;
  localparam int ST_EXT = 4;
  localparam int ST_PERM = 3;
  localparam int ST_ACC = 2;
  localparam int ST_TRANS = 1;

  // syndrome field positions
  localparam int SY_BANK_HI = 23;
  localparam int SY_BANK_LO = 16;
  localparam int SY_ASYNC = 11;
  localparam int SY_WALK = 10;
  localparam int SY_SEC = 8;
  localparam int SY_INSTR = 6;
  localparam int SY_PRIV = 5;
  localparam int SY_WRITE = 4;
  localparam int SY_LVL_HI = 1;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] LVL0 = 2'h0;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] FMT_SHORT = 2'h0;

  typedef enum logic [2:0] {
    K_WALK,
    K_TRANS,
    K_ACCESS,
    K_PERM,
    K_OTHER
  } fault_kind_t;

  // one fault report from the translation pipeline
  typedef struct packed {
    logic valid;
    logic unsupported_request_fault;
    logic addr_size_fault;
    logic tlb_lock_fault;
    logic tlb_multi_match_fault;
    logic external_fault;
    logic permission_fault;
    logic access_flag_fault;
    logic translation_fault;
    logic stall;
    fault_kind_t kind;
    logic [1:0] table_level;
    logic walk_disabled;
    logic [7:0] first_stage_bank_index;
    logic async_recorded;
    logic security_attribute;
    logic instruction_flag;
    logic privileged_flag;
    logic write_flag;
    logic far_atomic;
    logic atomic_read_missing;
    logic atomic_write_missing;
  } fault_rec_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : fault_regs_pkg

// File: src/context_fault_syndrome_regs.sv
/*
  per-bank fault status, restore, syndrome and memory type index registers.
  assumes fault reports arrive as one-cycle valid pulses on clk_sys and the
  register master follows the plain strobe protocol.
*/
`timescale 1ns/1ps
module context_fault_syndrome_regs #(
  parameter bit HAS_TLB_LOCK = 1'b1,
  parameter bit HAS_MULTI_MATCH = 1'b1,
  parameter bit HAS_EXT_DETECT = 1'b1,
  parameter bit HAS_NESTED = 1'b1,
  parameter bit SECURE_BANK = 1'b1,
  parameter bit SCHEME_64 = 1'b1,
  parameter int BANK_IDX_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire fault_regs_pkg::reg_req_t req,
  output logic [31:0] rdata,
  // fault reports
  input wire fault_regs_pkg::fault_rec_t fault,
  // bank configuration
  input wire logic [1:0] scheme_format,
  // state for the translation logic
  output logic stalled,
  output logic fault_pending,
  output logic [31:0] mem_type_low,
  output logic [31:0] mem_type_high
);
  import fault_regs_pkg::*;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] syn_pri;
    logic [31:0] syn_ext;
    logic [31:0] mem_low;
    logic [31:0] mem_high;
    logic [31:0] rdata;
  } state_t;

  // bits software may clear or restore; unsupported detectors read zero
  localparam logic [31:0] FLAG_MASK = (32'h1 << ST_REPEAT) | (32'h1 << ST_UNSUP)
    | (32'h1 << ST_ASIZE) | (32'(HAS_TLB_LOCK) << ST_TLBLK)
    | (32'(HAS_MULTI_MATCH) << ST_TLBMM) | (32'(HAS_EXT_DETECT) << ST_EXT)
    | (32'h1 << ST_PERM) | (32'h1 << ST_ACC) | (32'h1 << ST_TRANS);

  localparam logic [31:0] SYN_W_MASK = ((HAS_NESTED ? 32'hff : 32'h0) << SY_BANK_LO)
    | (32'h1 << SY_ASYNC) | (32'h1 << SY_WALK) | (32'(SECURE_BANK) << SY_SEC)
    | (32'h1 << SY_INSTR) | (32'h1 << SY_PRIV) | (32'h1 << SY_WRITE) | 32'h3;

  state_t cur_ff;
  state_t nxt_ff;
  // kept apart from the state struct: it alone runs on the raw reset
  logic [1:0] rst_sync_ff;
  logic rst_int_b;

  assign rst_int_b = rst_sync_ff[1];

  // level reported for the fault kind
  function automatic logic [1:0] pick_level(input fault_rec_t f);
    logic [1:0] lvl;
    lvl = f.table_level;
    if (f.kind == K_TRANS && f.walk_disabled) begin
      lvl = SCHEME_64 ? LVL0 : LVL1;
    end
    return lvl;
  endfunction : pick_level

  function automatic logic [31:0] build_syndrome(input fault_rec_t f);
    logic [31:0] s;
    logic [7:0] idx;
    s = REG_RESET;
    idx = 8'h00;
    idx[BANK_IDX_W-1:0] = f.first_stage_bank_index[BANK_IDX_W-1:0];
    if (HAS_NESTED) begin
      s[SY_BANK_HI:SY_BANK_LO] = idx;
    end
    s[SY_ASYNC] = f.async_recorded;
    s[SY_WALK] = f.external_fault && f.kind == K_WALK;
    s[SY_SEC] = SECURE_BANK & f.security_attribute;
    s[SY_INSTR] = f.instruction_flag;
    s[SY_PRIV] = f.privileged_flag;
    if (f.far_atomic) begin
      // only a lone missing write permission reports write
      s[SY_WRITE] = f.atomic_write_missing & ~f.atomic_read_missing
        & ~(f.translation_fault | f.access_flag_fault | f.external_fault);
    end else begin
      s[SY_WRITE] = f.write_flag;
    end
    s[SY_LVL_HI:0] = pick_level(f);
    return s;
  endfunction : build_syndrome

  always_comb begin
    logic [31:0] flags;
    logic [31:0] clr;
    flags = REG_RESET;
    clr = REG_RESET;
    nxt_ff = cur_ff;
    nxt_ff.rdata = REG_RESET;

    // software side first so a same-cycle fault wins over a clear
    if (req.wr) begin
      unique case (req.addr)
        STATUS_OFS: begin
          clr = req.wdata & FLAG_MASK;
          nxt_ff.status = cur_ff.status & ~clr;
        end
        RESTORE_OFS: begin
          nxt_ff.status = (cur_ff.status & ~FLAG_MASK) | (req.wdata & FLAG_MASK);
        end
        SYN_PRI_OFS: nxt_ff.syn_pri = req.wdata & SYN_W_MASK;
        SYN_EXT_OFS: nxt_ff.syn_ext = req.wdata;
        MEM_LOW_OFS: nxt_ff.mem_low = req.wdata;
        MEM_HIGH_OFS: nxt_ff.mem_high = req.wdata;
        RESUME_OFS: nxt_ff.status[ST_STALL] = 1'b0;
        default: ;
      endcase
    end

    if (fault.valid) begin
      flags[ST_UNSUP] = fault.unsupported_request_fault;
      flags[ST_ASIZE] = fault.addr_size_fault;
      flags[ST_TLBLK] = fault.tlb_lock_fault;
      flags[ST_TLBMM] = fault.tlb_multi_match_fault;
      flags[ST_EXT] = fault.external_fault;
      flags[ST_PERM] = fault.permission_fault;
      flags[ST_ACC] = fault.access_flag_fault;
      flags[ST_TRANS] = fault.translation_fault;
      flags = flags & FLAG_MASK;
      if ((cur_ff.status & FLAG_MASK) != REG_RESET) begin
        // keep the first syndrome; merge the new flags and mark the repeat
        nxt_ff.status = nxt_ff.status | flags | (32'h1 << ST_REPEAT);
      end else begin
        nxt_ff.status = nxt_ff.status | flags;
        nxt_ff.syn_pri = build_syndrome(fault);
      end
      if (fault.stall) begin
        nxt_ff.status[ST_STALL] = 1'b1;
      end
    end
    nxt_ff.status[ST_FMT_HI:ST_FMT_LO] = scheme_format;

    if (req.rd) begin
      unique case (req.addr)
        STATUS_OFS: nxt_ff.rdata = cur_ff.status;
        SYN_PRI_OFS: nxt_ff.rdata = cur_ff.syn_pri;
        SYN_EXT_OFS: nxt_ff.rdata = cur_ff.syn_ext;
        MEM_LOW_OFS: nxt_ff.rdata = cur_ff.mem_low;
        MEM_HIGH_OFS: nxt_ff.rdata = cur_ff.mem_high;
        default: nxt_ff.rdata = REG_RESET;
      endcase
    end
  end

  // reset synchroniser uses the raw reset; the rest uses its released copy
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_int_b) begin
    if (!rst_int_b) begin
      cur_ff.status <= REG_RESET;
      cur_ff.syn_pri <= REG_RESET;
      cur_ff.syn_ext <= REG_RESET;
      cur_ff.mem_low <= REG_RESET;
      cur_ff.mem_high <= REG_RESET;
      cur_ff.rdata <= REG_RESET;
    end else begin
      cur_ff.status <= nxt_ff.status;
      cur_ff.syn_pri <= nxt_ff.syn_pri;
      cur_ff.syn_ext <= nxt_ff.syn_ext;
      cur_ff.mem_low <= nxt_ff.mem_low;
      cur_ff.mem_high <= nxt_ff.mem_high;
      cur_ff.rdata <= nxt_ff.rdata;
    end
  end

  assign rdata = cur_ff.rdata;
  assign stalled = cur_ff.status[ST_STALL];
  assign fault_pending = (cur_ff.status & FLAG_MASK) != REG_RESET;
  assign mem_type_low = cur_ff.mem_low;
  assign mem_type_high = cur_ff.mem_high;

endmodule : context_fault_syndrome_regs

// File: testbench/context_fault_syndrome_regs_assertions.sv
/*
  port-level checks for the fault status, restore and memory type registers.
  assumes the plain strobe register port and one-cycle fault pulses on clk_sys.
*/
`timescale 1ns/1ps
module fault_regs_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire fault_regs_pkg::reg_req_t req,
  input wire logic [31:0] rdata,
  // fault reports and configuration
  input wire fault_regs_pkg::fault_rec_t fault,
  input wire logic [1:0] scheme_format,
  // state outputs
  input wire logic stalled,
  input wire logic fault_pending,
  input wire logic [31:0] mem_type_low,
  input wire logic [31:0] mem_type_high
);
  import fault_regs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_stall_fault;
    fault.valid && fault.stall;
  endsequence
  sequence s_rd_status;
    req.rd && req.addr == STATUS_OFS;
  endsequence
  property p_restore_rd;
    req.rd && req.addr == RESTORE_OFS |=> rdata == 32'h0;
  endproperty
  a_restore_rd: assert property (p_restore_rd) else $error("restore read not zero");
  property p_fmt;
    s_rd_status ##0 $stable(scheme_format) |=> rdata[10:9] == $past(scheme_format);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format field wrong");
  property p_stall_set;
    s_stall_fault |=> stalled;
  endproperty
  a_stall_set: assert property (p_stall_set) else $error("stall not recorded");
  property p_stall_hold;
    stalled && !(req.wr && req.addr == RESUME_OFS) |=> stalled;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall lost");
  property p_stall_clear;
    req.wr && req.addr == RESUME_OFS && !fault.valid |=> !stalled;
  endproperty
  a_stall_clear: assert property (p_stall_clear) else $error("resume kept stall");
  property p_pend_set;
    fault.valid && fault.translation_fault |=> fault_pending;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("fault not pending");
  property p_pend_hold;
    fault_pending && !req.wr |=> fault_pending;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending lost");
  property p_pend_clear;
    req.wr && req.addr == STATUS_OFS && req.wdata == 32'hffff_ffff && !fault.valid
      |=> !fault_pending;
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("clear failed");
  property p_mem_low;
    req.wr && req.addr == MEM_LOW_OFS |=> mem_type_low == $past(req.wdata);
  endproperty
  a_mem_low: assert property (p_mem_low) else $error("low index wrong");
  property p_mem_high;
    !(req.wr && req.addr == MEM_HIGH_OFS) |=> $stable(mem_type_high);
  endproperty
  a_mem_high: assert property (p_mem_high) else $error("high index moved");
endmodule : fault_regs_checker

// File: testbench/tb_context_fault_syndrome_regs.sv
/*
  self-checking bench for the fault status, syndrome and memory type registers.
  assumes default parameters: every fault kind, nested, secure bank, 64-bit scheme.
*/
`timescale 1ns/1ps
module tb_context_fault_syndrome_regs;
  import fault_regs_pkg::*;
  logic clk_sys;
  logic rst_b;
  reg_req_t req;
  logic [31:0] rdata;
  fault_rec_t fault;
  logic [1:0] scheme_format;
  logic stalled;
  logic fault_pending;
  logic [31:0] mem_type_low;
  logic [31:0] mem_type_high;
  int failures;
  int checked;
  fault_rec_t f;
  logic [31:0] fm;

  context_fault_syndrome_regs context_fault_syndrome_regs_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata), .fault(fault),
    .scheme_format(scheme_format), .stalled(stalled), .fault_pending(fault_pending),
    .mem_type_low(mem_type_low), .mem_type_high(mem_type_high));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // every access ends one idle cycle later so strobes never get two writes per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1;
    chk(rdata, exp);
    @(posedge clk_sys);
  endtask : rd
  task automatic hit(input fault_rec_t x);
    x.valid = 1'b1;
    fault <= x;
    @(posedge clk_sys);
    fault <= '0;
    @(posedge clk_sys);
  endtask : hit
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    req = '0;
    fault = '0;
    scheme_format = 2'h2;
    failures = 0;
    checked = 0;
    fm = 32'h0000_0400;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(STATUS_OFS, fm);
    for (int a = 4; a < 36; a += 4) rd(8'(a), 32'h0);
    $display("reset map done");
    for (int i = 1; i < 9; i++) begin
      f = '0;
      {f.unsupported_request_fault, f.addr_size_fault, f.tlb_lock_fault,
       f.tlb_multi_match_fault, f.external_fault, f.permission_fault,
       f.access_flag_fault, f.translation_fault} = 8'(1 << (i - 1));
      hit(f);
      wr(STATUS_OFS, 32'h1fe ^ (32'h1 << i));
      rd(STATUS_OFS, fm | (32'h1 << i));
      wr(STATUS_OFS, 32'h1 << i);
      rd(STATUS_OFS, fm);
      chk(32'(fault_pending), 32'h0);
    end
    $display("flags done");
    f = '0;
    f.translation_fault = 1'b1;
    f.kind = K_TRANS;
    f.table_level = 2'h3;
    f.first_stage_bank_index = 8'h5a;
    f.async_recorded = 1'b1;
    f.security_attribute = 1'b1;
    f.instruction_flag = 1'b1;
    f.privileged_flag = 1'b1;
    f.write_flag = 1'b1;
    hit(f);
    f = '0;
    f.external_fault = 1'b1;
    hit(f);
    rd(SYN_PRI_OFS, 32'h005a_0973);
    rd(STATUS_OFS, fm | 32'h8000_0012);
    wr(STATUS_OFS, 32'hffff_ffff);
    f.kind = K_WALK;
    f.table_level = 2'h1;
    hit(f);
    rd(SYN_PRI_OFS, 32'h0000_0401);
    wr(STATUS_OFS, 32'hffff_ffff);
    f = '0;
    f.translation_fault = 1'b1;
    f.kind = K_TRANS;
    f.walk_disabled = 1'b1;
    f.table_level = 2'h3;
    hit(f);
    rd(SYN_PRI_OFS, 32'h0);
    wr(STATUS_OFS, 32'hffff_ffff);
    f = '0;
    f.permission_fault = 1'b1;
    f.kind = K_PERM;
    f.far_atomic = 1'b1;
    f.atomic_write_missing = 1'b1;
    f.table_level = 2'h2;
    for (int k = 0; k < 2; k++) begin
      f.atomic_read_missing = k[0];
      hit(f);
      rd(SYN_PRI_OFS, k ? 32'h2 : 32'h12);
      wr(STATUS_OFS, 32'hffff_ffff);
    end
    $display("syndrome done");
    f = '0;
    f.translation_fault = 1'b1;
    f.stall = 1'b1;
    hit(f);
    @(negedge clk_sys);
    chk(32'(stalled), 32'h1);
    chk(32'(fault_pending), 32'h1);
    @(posedge clk_sys);
    wr(RESTORE_OFS, 32'h8000_0608);
    rd(STATUS_OFS, fm | 32'hc000_0008);
    wr(STATUS_OFS, 32'hffff_ffff);
    rd(STATUS_OFS, fm | 32'h4000_0000);
    wr(RESUME_OFS, 32'h0);
    rd(STATUS_OFS, fm);
    $display("stall done");
    scheme_format <= 2'h1;
    fm = 32'h0000_0200;
    wr(MEM_LOW_OFS, 32'h0302_0100);
    wr(MEM_HIGH_OFS, 32'h0706_0504);
    rd(MEM_LOW_OFS, 32'h0302_0100);
    rd(MEM_HIGH_OFS, 32'h0706_0504);
    chk(mem_type_low, 32'h0302_0100);
    chk(mem_type_high, 32'h0706_0504);
    wr(SYN_EXT_OFS, 32'ha5a5_5a5a);
    rd(SYN_EXT_OFS, 32'ha5a5_5a5a);
    wr(SYN_PRI_OFS, 32'hffff_ffff);
    rd(SYN_PRI_OFS, 32'h00ff_0d73);
    rd(STATUS_OFS, fm);
    $display("registers done");
    results();
  end
endmodule : tb_context_fault_syndrome_regs

bind context_fault_syndrome_regs fault_regs_checker fault_regs_checker_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata), .fault(fault),
  .scheme_format(scheme_format), .stalled(stalled), .fault_pending(fault_pending),
  .mem_type_low(mem_type_low), .mem_type_high(mem_type_high));
